/* hw/sctst_pkg.sv */
// Summary of operation
// - ATA status only reports acceptance or error, never SCT action completion.
// - status information is returned as log page E0h contents.
// - status request always accepted; never changes power state or background work. Here it is refused while en_q is clear or a page is in progress.
// - bytes 1:0 hold format version 0003h.
// - bytes 5:4 hold spec level 0001h; bytes 3:2 vendor implementation version.
// - bytes 9:6 bit 0 set after error-free full write-same; others reserved.
// - any user LBA write clears segment-initialized bit, cached or not. Here a write in the same cycle as ws_all_ok_i leaves it set.
// - capacity change by max-address or overlay clears segment-initialized bit. Here not when ws_all_ok_i is set in the same cycle.
// - segment-initialized bit is kept nonvolatile across power cycles.
// - byte 10 drive state code 0 to 5.
// - bytes 15:14 last SCT outcome, FFFFh while running in background.
// - bytes 17:16 action code of last or running SCT command.
// - bytes 19:18 function code of last or running SCT command.
// - bytes 47:40 current background LBA quadword.
// - byte 200 current HDA temperature, signed, 80h invalid.
// - bytes 201, 202 min and max temperature, 80h invalid.
// - bytes 203, 204 lifetime min and max temperature, 80h invalid.
package sctst_pkg;
   // =========================================================
   // command decode values
   localparam logic [7:0]  SCTST_CMD_SMART   = 8'hB0;
   localparam logic [7:0]  SCTST_CMD_LOGEXT  = 8'h2F;
   localparam logic [7:0]  SCTST_FEAT_RDLOG  = 8'hD5;
   localparam logic [7:0]  SCTST_PAGE_STAT   = 8'hE0;
   localparam logic [7:0]  SCTST_SMART_CYLLO = 8'h4F;
   localparam logic [7:0]  SCTST_SMART_CYLHI = 8'hC2;
   localparam logic [15:0] SCTST_COUNT_ONE   = 16'h0001;
   localparam logic [7:0]  SCTST_STAT_OK     = 8'h50;
   localparam logic [7:0]  SCTST_STAT_ERR    = 8'h51;
   localparam logic [7:0]  SCTST_ERR_ABORT   = 8'h04;
   // =========================================================
   // page layout
   localparam logic [15:0] SCTST_FMT_VER     = 16'h0003;
   localparam logic [15:0] SCTST_SPEC_VER    = 16'h0001;
   localparam logic [15:0] SCTST_EXT_RUNNING = 16'hFFFF;
   localparam logic [7:0]  SCTST_TEMP_INVAL  = 8'h80;
   localparam int          SCTST_PAGE_BYTES  = 512;
   localparam logic [9:0]  SCTST_LAST_IDX    = 10'h1FF;
   localparam logic [9:0]  SCTST_OFS_VEND    = 10'h002;
   localparam logic [9:0]  SCTST_OFS_SPEC    = 10'h004;
   localparam logic [9:0]  SCTST_OFS_FLAGS   = 10'h006;
   localparam logic [9:0]  SCTST_OFS_STATE   = 10'h00A;
   localparam logic [9:0]  SCTST_OFS_EXT     = 10'h00E;
   localparam logic [9:0]  SCTST_OFS_ACT     = 10'h010;
   localparam logic [9:0]  SCTST_OFS_FUNC    = 10'h012;
   localparam logic [9:0]  SCTST_OFS_LBA     = 10'h028;
   localparam logic [9:0]  SCTST_OFS_TEMP    = 10'h0C8;
   localparam logic [9:0]  SCTST_OFS_TEMP_END = 10'h0CD;
   localparam int          SCTST_TEMP_CNT    = 5;
   // =========================================================
   // register map (byte addresses)
   localparam logic [3:0]  SCTST_REG_CTRL    = 4'h0;
   localparam logic [3:0]  SCTST_REG_VEND    = 4'h4;
   localparam logic [3:0]  SCTST_REG_STAT    = 4'h8;
   localparam logic [3:0]  SCTST_REG_COUNT   = 4'hC;
   localparam logic [15:0] SCTST_VEND_RST    = 16'h0100; // arbitrary value
   localparam logic        SCTST_EN_RST      = 1'b1;

   typedef enum logic [1:0] {
      SCTST_IDLE = 2'b00,
      SCTST_SEND = 2'b01,
      SCTST_FIN  = 2'b11
   } sctst_state_e;
endpackage : sctst_pkg

/* hw/sctst_status_log_page.sv */
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sctst_status_log_page
   import sctst_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // task file of a log read command
   input  wire logic        tf_valid_i,
   input  wire logic [7:0]  tf_cmd_i,
   input  wire logic [7:0]  tf_feature_i,
   input  wire logic [15:0] tf_count_i,
   input  wire logic [15:0] tf_lba_lo_i,
   input  wire logic [15:0] tf_lba_mid_i,
   input  wire logic [15:0] tf_lba_hi_i,
   output logic             ata_done_o,
   output logic      [7:0]  ata_status_o,
   output logic      [7:0]  ata_error_o,
   // page byte stream
   output logic      [7:0]  pg_data_o,
   output logic             pg_valid_o,
   output logic             pg_last_o,
   input  wire logic        pg_ready_i,
   // drive state from surrounding logic
   input  wire logic [2:0]  drv_state_i,
   input  wire logic [15:0] sct_ext_status_i,
   input  wire logic [15:0] sct_action_i,
   input  wire logic [15:0] sct_function_i,
   input  wire logic [63:0] sct_lba_i,
   input  wire logic [7:0]  temp_now_i,
   input  wire logic [7:0]  temp_min_i,
   input  wire logic [7:0]  temp_max_i,
   input  wire logic [7:0]  temp_life_min_i,
   input  wire logic [7:0]  temp_life_max_i,
   input  wire logic [4:0]  temp_valid_i,
   // segment-initialized flag events and its nonvolatile copy
   input  wire logic        ws_all_ok_i,
   input  wire logic        user_write_i,
   input  wire logic        capacity_chg_i,
   input  wire logic        nv_seg_i,
   output logic             nv_seg_o,
   output logic             nv_seg_we_o
);
   // =========================================================
   // sequencer state, registers, flag and the snapshot taken when a request is accepted
   sctst_state_e state_q;
   logic [9:0]   idx_q;
   logic         idx_wrap_q;
   logic [15:0]  vend_q;
   logic         en_q;
   logic [15:0]  served_q;
   logic         seg_q;
   logic         nv_loaded_q;
   logic [7:0]   snap_state_q;
   logic [15:0]  snap_ext_q;
   logic [15:0]  snap_act_q;
   logic [15:0]  snap_func_q;
   logic [63:0]  snap_lba_q;
   logic [39:0]  snap_temp_q;
   logic         snap_seg_q;
   logic         is_smart;
   logic         is_logext;
   logic         take;
   logic         adv;
   logic [7:0]   page_byte;
   logic [39:0]  temps;
   logic [39:0]  temp_raw;
   logic [15:0]  snap_vend_q;
   logic         seg_base;
   logic         seg_d;
   logic         seg_chg_q;
   logic         refuse_pend_q;

   // =========================================================
   // request decode
   assign is_smart  = (tf_cmd_i == SCTST_CMD_SMART) && (tf_feature_i == SCTST_FEAT_RDLOG)
                   && (tf_count_i[7:0] == SCTST_COUNT_ONE[7:0])
                   && (tf_lba_lo_i[7:0] == SCTST_PAGE_STAT)
                   && (tf_lba_mid_i[7:0] == SCTST_SMART_CYLLO)
                   && (tf_lba_hi_i[7:0] == SCTST_SMART_CYLHI);
   assign is_logext = (tf_cmd_i == SCTST_CMD_LOGEXT) && (tf_count_i == SCTST_COUNT_ONE)
                   && (tf_lba_lo_i[7:0] == SCTST_PAGE_STAT)
                   && (tf_lba_mid_i == 16'h0000);
   assign take = tf_valid_i && (state_q == SCTST_IDLE) && en_q && (is_smart || is_logext);
   assign adv  = !pg_valid_o || pg_ready_i;

   // invalid temperatures forced to the marker byte
   assign temp_raw = {temp_life_max_i, temp_life_min_i, temp_max_i, temp_min_i, temp_now_i};
   for (genvar g = 0; g < SCTST_TEMP_CNT; g++) begin : g_temp
      assign temps[g*8 +: 8] = temp_valid_i[g] ? temp_raw[g*8 +: 8] : SCTST_TEMP_INVAL;
   end

   // =========================================================
   // sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q    <= SCTST_IDLE;
         idx_q      <= 10'h000;
         idx_wrap_q <= 1'b0;
      end else begin
         case (state_q)
            SCTST_IDLE: begin
               idx_q      <= 10'h000;
               idx_wrap_q <= 1'b0;
               if (take) begin
                  state_q <= SCTST_SEND;
               end
            end
            SCTST_SEND: begin
               if (adv) begin
                  if (idx_wrap_q) begin
                     state_q <= SCTST_FIN;
                  end else begin
                     idx_q      <= idx_q + 10'h001;
                     idx_wrap_q <= (idx_q == SCTST_LAST_IDX);
                  end
               end
            end
            SCTST_FIN: begin
               state_q <= SCTST_IDLE;
            end
            default: begin
               state_q <= SCTST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_state_q <= 8'h00;
         snap_ext_q   <= 16'h0000;
         snap_act_q   <= 16'h0000;
         snap_func_q  <= 16'h0000;
         snap_lba_q   <= 64'h0;
         snap_temp_q  <= 40'h0;
         snap_seg_q   <= 1'b0;
         snap_vend_q  <= 16'h0000;
      end else if (take) begin
         snap_state_q <= {5'h00, drv_state_i};
         snap_ext_q   <= sct_ext_status_i;
         snap_act_q   <= sct_action_i;
         snap_func_q  <= sct_function_i;
         snap_lba_q   <= sct_lba_i;
         snap_temp_q  <= temps;
         snap_seg_q   <= seg_q;
         snap_vend_q  <= vend_q;
      end
   end

   // =========================================================
   // page contents
   always_comb begin
      page_byte = 8'h00;
      if (idx_q < SCTST_OFS_VEND) begin
         page_byte = SCTST_FMT_VER[idx_q[0]*8 +: 8];
      end else if (idx_q < SCTST_OFS_SPEC) begin
         page_byte = snap_vend_q[idx_q[0]*8 +: 8];
      end else if (idx_q < SCTST_OFS_FLAGS) begin
         page_byte = SCTST_SPEC_VER[idx_q[0]*8 +: 8];
      end else if (idx_q == SCTST_OFS_FLAGS) begin
         page_byte = {7'h00, snap_seg_q};
      end else if (idx_q == SCTST_OFS_STATE) begin
         page_byte = snap_state_q;
      end else if (idx_q[9:1] == SCTST_OFS_EXT[9:1]) begin
         page_byte = snap_ext_q[idx_q[0]*8 +: 8];
      end else if (idx_q[9:1] == SCTST_OFS_ACT[9:1]) begin
         page_byte = snap_act_q[idx_q[0]*8 +: 8];
      end else if (idx_q[9:1] == SCTST_OFS_FUNC[9:1]) begin
         page_byte = snap_func_q[idx_q[0]*8 +: 8];
      end else if (idx_q[9:3] == SCTST_OFS_LBA[9:3]) begin
         page_byte = snap_lba_q[idx_q[2:0]*8 +: 8];
      end else if ((idx_q >= SCTST_OFS_TEMP) && (idx_q < SCTST_OFS_TEMP_END)) begin
         page_byte = snap_temp_q[(idx_q - SCTST_OFS_TEMP)*8 +: 8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pg_data_o  <= 8'h00;
         pg_valid_o <= 1'b0;
         pg_last_o  <= 1'b0;
      end else if (state_q == SCTST_SEND && adv) begin
         pg_data_o  <= page_byte;
         pg_valid_o <= !idx_wrap_q;
         pg_last_o  <= (idx_q == SCTST_LAST_IDX);
      end else if (adv) begin
         pg_valid_o <= 1'b0;
         pg_last_o  <= 1'b0;
      end
   end

   // refusal meeting a page completion is reported one cycle late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refuse_pend_q <= 1'b0;
      end else begin
         refuse_pend_q <= (state_q == SCTST_FIN) && tf_valid_i && !take;
      end
   end

   // acceptance or error only; the SCT action itself is untouched
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ata_done_o   <= 1'b0;
         ata_status_o <= SCTST_STAT_OK;
         ata_error_o  <= 8'h00;
      end else if (state_q == SCTST_FIN) begin
         ata_done_o   <= 1'b1;
         ata_status_o <= SCTST_STAT_OK;
         ata_error_o  <= 8'h00;
      end else if ((tf_valid_i && !take) || refuse_pend_q) begin
         ata_done_o   <= 1'b1;
         ata_status_o <= SCTST_STAT_ERR;
         ata_error_o  <= SCTST_ERR_ABORT;
      end else begin
         ata_done_o   <= 1'b0;
      end
   end

   // =========================================================
   // segment-initialized flag, nonvolatile copy
   // set wins over clear; events in the load cycle are not lost
   always_comb begin
      seg_base = nv_loaded_q ? seg_q : nv_seg_i;
      seg_d    = seg_base;
      if (ws_all_ok_i) begin
         seg_d = 1'b1;
      end else if (user_write_i || capacity_chg_i) begin
         seg_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seg_q       <= 1'b0;
         nv_loaded_q <= 1'b0;
         seg_chg_q   <= 1'b0;
      end else begin
         seg_q       <= seg_d;
         nv_loaded_q <= 1'b1;
         seg_chg_q   <= (seg_d != seg_base);
      end
   end

   // store strobe aligned with the copy it stores
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv_seg_o    <= 1'b0;
         nv_seg_we_o <= 1'b0;
      end else begin
         nv_seg_o    <= seg_q;
         nv_seg_we_o <= seg_chg_q;
      end
   end

   // =========================================================
   // wishbone registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q   <= SCTST_EN_RST;
         vend_q <= SCTST_VEND_RST;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
         if (wb_adr_i == SCTST_REG_CTRL && wb_sel_i[0]) begin
            en_q <= wb_dat_i[0];
         end
         if (wb_adr_i == SCTST_REG_VEND) begin
            if (wb_sel_i[0]) begin
               vend_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               vend_q[15:8] <= wb_dat_i[15:8];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         served_q <= 16'h0000;
      end else if (state_q == SCTST_FIN) begin
         served_q <= served_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (wb_adr_i)
            SCTST_REG_CTRL:  wb_dat_o <= {31'h0, en_q};
            SCTST_REG_VEND:  wb_dat_o <= {16'h0, vend_q};
            SCTST_REG_STAT:  wb_dat_o <= {29'h0, state_q == SCTST_SEND, state_q != SCTST_IDLE, seg_q};
            SCTST_REG_COUNT: wb_dat_o <= {16'h0, served_q};
            default:         wb_dat_o <= 32'h0;
         endcase
      end
   end
endmodule : sctst_status_log_page
`default_nettype wire

/* testbench/sctst_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sctst_host_model
   import sctst_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        slow_i,
   output logic             tf_valid_o,
   output logic      [7:0]  tf_cmd_o,
   output logic      [7:0]  tf_feature_o,
   output logic      [15:0] tf_count_o,
   output logic      [15:0] tf_lba_lo_o,
   output logic      [15:0] tf_lba_mid_o,
   output logic      [15:0] tf_lba_hi_o,
   input  wire logic [7:0]  pg_data_i,
   input  wire logic        pg_valid_i,
   input  wire logic        pg_last_i,
   output logic             pg_ready_o
);
   // ==========================================
   // page sink, stalls three of four cycles when slow
   logic [7:0] page [0:511];
   logic [9:0] n_q;
   logic [9:0] last_n_q;
   logic [1:0] pace_q;
   initial {tf_valid_o, tf_cmd_o, tf_feature_o, tf_count_o, tf_lba_lo_o, tf_lba_mid_o, tf_lba_hi_o} = '0;
   assign pg_ready_o = !slow_i || pace_q == 2'h3;
   always_ff @(posedge clk_i) begin
      pace_q <= rst_i ? 2'h0 : pace_q + 2'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         n_q <= 10'h000;
      end else if (pg_valid_i && pg_ready_o) begin
         page[n_q] <= pg_data_i;
         n_q <= pg_last_i ? 10'h000 : n_q + 10'h001;
         if (pg_last_i) last_n_q <= n_q;
      end
   end
   task issue(input logic [7:0] c, f, input logic [15:0] n, lo, mid, hi);
      @(posedge clk_i);
      {tf_valid_o, tf_cmd_o, tf_feature_o, tf_count_o, tf_lba_lo_o, tf_lba_mid_o, tf_lba_hi_o}
         <= {1'b1, c, f, n, lo, mid, hi};
      @(posedge clk_i);
      {tf_valid_o, tf_cmd_o} <= {1'b0, ~c};
   endtask : issue
   task smart_rd;
      issue(8'hB0, 8'hD5, 16'h0001, 16'h00E0, 16'h004F, 16'h00C2);
   endtask : smart_rd
   task ext_rd;
      issue(8'h2F, 8'h00, 16'h0001, 16'h00E0, 16'h0000, 16'h0000);
   endtask : ext_rd
endmodule : sctst_host_model
`default_nettype wire

/* testbench/sctst_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module sctst_monitor
   import sctst_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       tf_valid_i,
   input wire logic [7:0] tf_cmd_i,
   input wire logic [7:0] pg_data_o,
   input wire logic       pg_valid_o,
   input wire logic       pg_last_o,
   input wire logic       pg_ready_i,
   input wire logic       ata_done_o,
   input wire logic [7:0] ata_status_o,
   input wire logic [7:0] ata_error_o,
   input wire logic       ws_all_ok_i,
   input wire logic       user_write_i,
   input wire logic       capacity_chg_i,
   input wire logic       nv_seg_o,
   input wire logic       nv_seg_we_o
);
   // ==========================================
   // port checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_last_taken;
      pg_valid_o && pg_last_o && pg_ready_i;
   endsequence
   sequence s_ok_done;
      !pg_valid_o ##1 (ata_done_o && ata_status_o == SCTST_STAT_OK);
   endsequence
   AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_FMT_FIRST: assert property ($rose(pg_valid_o) |-> pg_data_o == SCTST_FMT_VER[7:0])
      else $error("first byte wrong");
   AST_HOLD: assert property (pg_valid_o && !pg_ready_i |=> pg_valid_o && $stable(pg_data_o))
      else $error("byte dropped");
   AST_END_LAST: assert property ($fell(pg_valid_o) |-> $past(pg_last_o))
      else $error("page cut short");
   AST_DONE_OK: assert property (s_last_taken |=> s_ok_done)
      else $error("done late");
   AST_REFUSE: assert property (tf_valid_i && tf_cmd_i != SCTST_CMD_SMART && tf_cmd_i != SCTST_CMD_LOGEXT
      |=> ata_done_o && ata_status_o == SCTST_STAT_ERR && ata_error_o == SCTST_ERR_ABORT)
      else $error("bad command not refused");
   AST_SET: assert property (ws_all_ok_i |-> ##[1:2] nv_seg_o)
      else $error("flag not set");
   AST_WR_CLR: assert property (user_write_i && !ws_all_ok_i |-> ##[1:2] !nv_seg_o)
      else $error("flag not cleared by write");
   AST_CAP_CLR: assert property (capacity_chg_i && !ws_all_ok_i |-> ##[1:2] !nv_seg_o)
      else $error("flag not cleared by capacity");
   AST_NV_WE: assert property (nv_seg_we_o |-> $changed(nv_seg_o))
      else $error("store strobe without new flag copy");
endmodule : sctst_monitor
bind sctst_status_log_page sctst_monitor sctst_monitor_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tf_valid_i, .tf_cmd_i, .pg_data_o, .pg_valid_o,
   .pg_last_o, .pg_ready_i, .ata_done_o, .ata_status_o, .ata_error_o, .ws_all_ok_i, .user_write_i,
   .capacity_chg_i, .nv_seg_o, .nv_seg_we_o);
`default_nettype wire

/* testbench/tb_sctst_status_log_page.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_sctst_status_log_page
   import sctst_pkg::*;
;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tf_valid_i, ata_done_o, slow, exp_flag;
   logic pg_valid_o, pg_last_o, pg_ready_i, ws_all_ok_i, user_write_i, capacity_chg_i;
   logic nv_seg_i, nv_seg_o, nv_seg_we_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [7:0] tf_cmd_i, tf_feature_i, ata_status_o, ata_error_o, pg_data_o;
   logic [7:0] temp_now_i, temp_min_i, temp_max_i, temp_life_min_i, temp_life_max_i;
   logic [15:0] tf_count_i, tf_lba_lo_i, tf_lba_mid_i, tf_lba_hi_i, vend;
   logic [15:0] sct_ext_status_i, sct_action_i, sct_function_i;
   logic [2:0] drv_state_i;
   logic [4:0] temp_valid_i;
   logic [63:0] sct_lba_i;
   int fails = 0;
   int n_tests = 0;
   int cyc_n = 0;
   int we_n = 0;
   sctst_status_log_page sctst_status_log_page_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tf_valid_i, .tf_cmd_i, .tf_feature_i,
      .tf_count_i, .tf_lba_lo_i, .tf_lba_mid_i, .tf_lba_hi_i, .ata_done_o, .ata_status_o, .ata_error_o,
      .pg_data_o, .pg_valid_o, .pg_last_o, .pg_ready_i, .drv_state_i, .sct_ext_status_i, .sct_action_i,
      .sct_function_i, .sct_lba_i, .temp_now_i, .temp_min_i, .temp_max_i, .temp_life_min_i,
      .temp_life_max_i, .temp_valid_i, .ws_all_ok_i, .user_write_i, .capacity_chg_i, .nv_seg_i,
      .nv_seg_o, .nv_seg_we_o);
   sctst_host_model sctst_host_model_inst (.clk_i, .rst_i, .slow_i(slow), .tf_valid_o(tf_valid_i),
      .tf_cmd_o(tf_cmd_i), .tf_feature_o(tf_feature_i), .tf_count_o(tf_count_i), .tf_lba_lo_o(tf_lba_lo_i),
      .tf_lba_mid_o(tf_lba_mid_i), .tf_lba_hi_o(tf_lba_hi_i), .pg_data_i(pg_data_o),
      .pg_valid_i(pg_valid_o), .pg_last_i(pg_last_o), .pg_ready_o(pg_ready_i));
   // ==========================================
   // clock, timeout, helpers
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 30000) begin
         fails = fails + 1;
         final_report;
      end
   end
   always @(posedge clk_i) begin
      if (nv_seg_we_o === 1'b1) we_n <= we_n + 1;
   end
   task final_report;
      if (fails == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb_xfer
   task wait_done;
      do @(posedge clk_i); while (ata_done_o !== 1'b1);
   endtask : wait_done
   task flag_step(input logic [2:0] ev, input logic e);
      @(posedge clk_i);
      {ws_all_ok_i, user_write_i, capacity_chg_i} <= ev;
      @(posedge clk_i);
      {ws_all_ok_i, user_write_i, capacity_chg_i} <= 3'b000;
      exp_flag = e;
      wb_xfer(1'b0, SCTST_REG_STAT, 32'h0);
      chk("seg flag", {31'h0, e}, {31'h0, rd[0]});
      chk("nv copy", {31'h0, e}, {31'h0, nv_seg_o});
   endtask : flag_step
   function automatic logic [7:0] exp_b(input int i);
      logic [7:0] t [0:4];
      t = '{temp_now_i, temp_min_i, temp_max_i, temp_life_min_i, temp_life_max_i};
      if (i >= 40 && i <= 47) return sct_lba_i[8*(i-40) +: 8];
      if (i >= 200 && i <= 204) return temp_valid_i[i-200] ? t[i-200] : 8'h80;
      case (i)
         0: return 8'h03;
         2, 3: return vend[8*(i-2) +: 8];
         4: return 8'h01;
         6: return {7'h00, exp_flag};
         10: return {5'h00, drv_state_i};
         14, 15: return sct_ext_status_i[8*(i-14) +: 8];
         16, 17: return sct_action_i[8*(i-16) +: 8];
         18, 19: return sct_function_i[8*(i-18) +: 8];
         default: return 8'h00;
      endcase
   endfunction : exp_b
   task get_page(input logic smart);
      if (smart) sctst_host_model_inst.smart_rd;
      else sctst_host_model_inst.ext_rd;
      wait_done;
      chk("ok status", 32'h5000, {16'h0, ata_status_o, ata_error_o});
      for (int i = 0; i < 512; i++) chk("page byte", exp_b(i), {24'h0, sctst_host_model_inst.page[i]});
      chk("last index", 32'd511, {22'h0, sctst_host_model_inst.last_n_q});
   endtask : get_page
   // ==========================================
   // main sequence
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, ws_all_ok_i, user_write_i, capacity_chg_i} = 6'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i} = {4'h0, 4'hF, 32'h0};
      {temp_now_i, temp_min_i, temp_max_i, temp_life_min_i, temp_life_max_i} = 40'h19F62DEC3C;
      {sct_lba_i, sct_action_i, sct_function_i} = {64'h0123456789ABCDEF, 16'h0002, 16'h0001};
      {rst_i, nv_seg_i, exp_flag, slow, drv_state_i} = 7'h70;
      {sct_ext_status_i, temp_valid_i, vend} = {16'h0000, 5'h1F, 16'h0100};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_xfer(1'b0, SCTST_REG_COUNT, 32'h0);
      chk("count reset", 32'h0, rd);
      wb_xfer(1'b0, SCTST_REG_STAT, 32'h0);
      chk("flag restored", 32'h1, {31'h0, rd[0]});
      wb_xfer(1'b0, SCTST_REG_VEND, 32'h0);
      chk("vend reset", 32'h0100, rd);
      wb_xfer(1'b0, 4'h6, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb_xfer(1'b1, SCTST_REG_VEND, 32'h1234);
      vend = 16'h1234;
      flag_step(3'b010, 1'b0);
      flag_step(3'b110, 1'b1);
      flag_step(3'b001, 1'b0);
      flag_step(3'b100, 1'b1);
      chk("nv writes", 32'd4, we_n);
      for (int s = 0; s < 6; s++) begin
         drv_state_i <= s[2:0];
         sct_ext_status_i <= (s == 5) ? 16'hFFFF : 16'h0000;
         temp_valid_i <= 5'h1F >> s;
         slow <= s[0];
         @(posedge clk_i);
         get_page(s[1]);
      end
      sctst_host_model_inst.issue(8'hEC, 8'h00, 16'h0001, 16'h00E0, 16'h0, 16'h0);
      wait_done;
      chk("refused", 32'h5104, {16'h0, ata_status_o, ata_error_o});
      wb_xfer(1'b1, SCTST_REG_CTRL, 32'h0);
      sctst_host_model_inst.ext_rd;
      wait_done;
      chk("disabled", 32'h5104, {16'h0, ata_status_o, ata_error_o});
      wb_xfer(1'b0, SCTST_REG_COUNT, 32'h0);
      chk("pages served", 32'h6, rd);
      final_report;
   end
endmodule : tb_sctst_status_log_page
`default_nettype wire
